/* File: interrupt_split_descriptor_decode.sv */
// Decoder and scheduler for the lower word of an interrupt transfer descriptor
// What this block does
// - Split bit 46 selects split or high-speed
// - Token 00 OUT, 01 IN; kind 11 interrupt
// - Function address from bits 41 to 35
// - Endpoint number from bits 34:32 and 31
// - Max packet bits 28:18, FS/LS at most 64
// - Byte count bits 17:3, at most 4 kB
// - Hardware clears valid on completion or fatal error
// - Poll period is 2^(b-1) microframes
// - Speed code ignored for high-speed transactions
// - Active loaded from active_in; hardware clears it with valid at end
// - Retry counter decrements on each transaction error; an error at zero ends the transfer
`include "desc_decode_map.svh"
module interrupt_split_descriptor_decode
   import desc_decode_pkg::*;
#(
   parameter int UFRAME_CYCLES = `UFRAME_CYCLES
)(
   input  wire logic            sys_clk,
   input  wire logic            rst_n,
   input  wire logic            desc_load,
   input  wire logic [63:0]     desc_word,
   input  wire logic [7:0]      uframe_code,
   input  wire logic            active_in,
   input  wire logic [1:0]      cerr_in,
   input  wire logic            txn_done,
   input  wire logic [14:0]     done_bytes,
   input  wire logic            txn_err,
   input  wire logic            fatal_err,
   output desc_fields_type      fields_q,
   output token_type            token_q,
   output speed_type            speed_q,
   output logic                 is_interrupt_q,
   output logic                 param_fault_q,
   output logic                 valid_q,
   output logic                 active_q,
   output logic [1:0]           retry_q,
   output logic [14:0]          bytes_left_q,
   output logic                 txn_start_q,
   output logic                 busy
);
   // Exponent b from the rate code; code 00000 means b = 4, one millisecond
   function automatic logic [3:0] poll_b(input logic [4:0] code);
      logic [3:0] b;
      b = `POLL_B_MIN;
      casez (code)
         5'b1????: b = 4'h9;
         5'b01???: b = 4'h8;
         5'b001??: b = 4'h7;
         5'b0001?: b = 4'h6;
         5'b00001: b = 4'h5;
         default:  b = `POLL_B_MIN;
      endcase
      return b;
   endfunction

   function automatic speed_type decode_speed(input logic split, input logic [1:0] code);
      speed_type s;
      s = SPEED_HIGH;
      if (split)
      begin
         if (code == `SPEED_CODE_LOW)
            s = SPEED_LOW;
         else if (code == `SPEED_CODE_FULL)
            s = SPEED_FULL;
         else
            s = SPEED_BAD;
      end
      return s;
   endfunction

   desc_fields_type fields_d;
   token_type       token_d;
   speed_type       speed_d;
   state_type       state_q, state_d;
   logic            is_interrupt_d, param_fault_d, valid_d, active_d, txn_start_d;
   logic [1:0]      retry_d;
   logic [14:0]     bytes_left_d;
   logic [8:0]      period_q, period_d, poll_q, poll_d;
   logic [15:0]     tick_cnt_q, tick_cnt_d;
   logic            uframe_tick;

   // Free-running microframe timebase; polling is aligned to it, not to the load
   assign uframe_tick = (tick_cnt_q == 16'(UFRAME_CYCLES - 1));
   assign busy        = (state_q != ST_IDLE);

   always_comb
   begin
      tick_cnt_d = uframe_tick ? 16'h0000 : tick_cnt_q + 16'h0001;
   end

   always_comb
   begin
      fields_d       = fields_q;
      token_d        = token_q;
      speed_d        = speed_q;
      is_interrupt_d = is_interrupt_q;
      param_fault_d  = param_fault_q;
      valid_d        = valid_q;
      active_d       = active_q;
      retry_d        = retry_q;
      bytes_left_d   = bytes_left_q;
      period_d       = period_q;
      poll_d         = poll_q;
      state_d        = state_q;
      txn_start_d    = 1'b0;
      unique case (state_q)
         ST_IDLE: ;
         ST_WAIT:
            if (uframe_tick)
            begin
               if (poll_q == period_q - 9'h001)
               begin
                  poll_d  = 9'h000;
                  state_d = ST_ISSUE;
               end
               else
                  poll_d = poll_q + 9'h001;
            end
         ST_ISSUE:
         begin
            txn_start_d = 1'b1;
            state_d     = ST_BUSY;
         end
         ST_BUSY:
            if (txn_done)
            begin
               bytes_left_d = (done_bytes >= bytes_left_q) ? 15'h0000 : bytes_left_q - done_bytes;
               if (done_bytes >= bytes_left_q)
               begin
                  valid_d  = 1'b0;
                  active_d = 1'b0;
                  state_d  = ST_IDLE;
               end
               else
                  state_d = ST_WAIT;
            end
            else if (txn_err)
            begin
               if (retry_q == `RETRY_NONE)
               begin
                  valid_d  = 1'b0;
                  active_d = 1'b0;
                  state_d  = ST_IDLE;
               end
               else
               begin
                  retry_d = retry_q - 2'h1;
                  state_d = ST_WAIT;
               end
            end
      endcase
      if (fatal_err)
      begin
         valid_d  = 1'b0;
         active_d = 1'b0;
         state_d  = ST_IDLE;
      end
      // A new load wins over any clear in the same cycle
      if (desc_load)
      begin
         fields_d.split               = desc_word[`DESC_SPLIT_BIT];
         fields_d.endpoint_kind       = desc_word[`DESC_KIND_MSB:`DESC_KIND_LSB];
         fields_d.token_code          = desc_word[`DESC_TOKEN_MSB:`DESC_TOKEN_LSB];
         fields_d.split_speed_code    = desc_word[`DESC_SPEED_MSB:`DESC_SPEED_LSB];
         fields_d.function_addr       = desc_word[`DESC_ADDR_MSB:`DESC_ADDR_LSB];
         fields_d.endpoint_number     = {desc_word[`DESC_EP_HIGH_MSB:`DESC_EP_HIGH_LSB],
                                         desc_word[`DESC_EP_LOW_BIT]};
         fields_d.max_packet_len      = desc_word[`DESC_MAXLEN_MSB:`DESC_MAXLEN_LSB];
         fields_d.transfer_byte_count = desc_word[`DESC_BYTES_MSB:`DESC_BYTES_LSB];
         token_d = (fields_d.token_code == `TOKEN_CODE_OUT) ? TOKEN_OUT :
                   (fields_d.token_code == `TOKEN_CODE_IN)  ? TOKEN_IN : TOKEN_BAD;
         is_interrupt_d = (fields_d.endpoint_kind == `KIND_CODE_INTR);
         speed_d = decode_speed(fields_d.split, fields_d.split_speed_code);
         // Software limits are flagged, not enforced; the transfer still runs
         param_fault_d = (fields_d.split && fields_d.max_packet_len > `FSLS_MAX_PKT)
                       || (fields_d.transfer_byte_count > `XFER_MAX_BYTES);
         period_d = 9'h001 << (poll_b(uframe_code[7:3]) - 4'h1);
         poll_d       = 9'h000;
         retry_d      = cerr_in;
         bytes_left_d = fields_d.transfer_byte_count;
         valid_d      = desc_word[`DESC_VALID_BIT];
         active_d     = active_in;
         state_d      = desc_word[`DESC_VALID_BIT] ? ST_WAIT : ST_IDLE;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick_cnt_q     <= 16'h0000;
         fields_q       <= '0;
         token_q        <= TOKEN_OUT;
         speed_q        <= SPEED_HIGH;
         is_interrupt_q <= 1'b0;
         param_fault_q  <= 1'b0;
         valid_q        <= 1'b0;
         active_q       <= 1'b0;
         retry_q        <= 2'h0;
         bytes_left_q   <= 15'h0000;
         period_q       <= 9'h008;
         poll_q         <= 9'h000;
         state_q        <= ST_IDLE;
         txn_start_q    <= 1'b0;
      end
      else
      begin
         tick_cnt_q     <= tick_cnt_d;
         fields_q       <= fields_d;
         token_q        <= token_d;
         speed_q        <= speed_d;
         is_interrupt_q <= is_interrupt_d;
         param_fault_q  <= param_fault_d;
         valid_q        <= valid_d;
         active_q       <= active_d;
         retry_q        <= retry_d;
         bytes_left_q   <= bytes_left_d;
         period_q       <= period_d;
         poll_q         <= poll_d;
         state_q        <= state_d;
         txn_start_q    <= txn_start_d;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_split_select: assert property (desc_load |=> fields_q.split == $past(desc_word[46]))
      else $error("split bit not taken from bit 46");
   a_token_decode: assert property (desc_load && desc_word[43:42] == 2'h1 |=> token_q == TOKEN_IN && !is_interrupt_q == ($past(desc_word[45:44]) != 2'h3))
      else $error("token or kind decode wrong");
   a_addr_field: assert property (desc_load |=> fields_q.function_addr == $past(desc_word[41:35]))
      else $error("function address field wrong");
   a_endpoint_join: assert property (desc_load |=> fields_q.endpoint_number == {$past(desc_word[34:32]), $past(desc_word[31])})
      else $error("endpoint number assembled wrong");
   a_limit_flag: assert property (desc_load && desc_word[46] && desc_word[28:18] == 11'h041 |=> param_fault_q)
      else $error("oversize packet not flagged");
   a_valid_clear: assert property (fatal_err && !desc_load |=> !valid_q && !active_q && state_q == ST_IDLE)
      else $error("valid not cleared on fatal error");
   a_valid_arms: assert property (desc_load && desc_word[0] |=> valid_q && state_q == ST_WAIT)
      else $error("valid descriptor not armed");
   a_speed_ignored: assert property (desc_load && !desc_word[46] |=> speed_q == SPEED_HIGH)
      else $error("speed code used for high-speed");
   a_split_speed: assert property (desc_load && desc_word[46] && desc_word[49:48] == 2'h2 |=> speed_q == SPEED_LOW)
      else $error("low-speed split decode wrong");
   a_poll_period: assert property (desc_load && desc_word[0] && uframe_code[7:3] == 5'h01 |=> period_q == 9'h010)
      else $error("2 ms rate not 16 microframes");
   a_retry_step: assert property (state_q == ST_BUSY && txn_err && !txn_done && retry_q != 2'h0 && !fatal_err && !desc_load
                                  |=> retry_q == $past(retry_q) - 2'h1 ##0 state_q == ST_WAIT)
      else $error("retry counter not decremented");
   a_start_pulse: assert property (txn_start_q |=> !txn_start_q)
      else $error("transaction start longer than one cycle");

   c_split_run: cover property (txn_start_q && fields_q.split);
   c_finish: cover property ($fell(valid_q) && bytes_left_q == 15'h0000);
   c_retry_out: cover property (state_q == ST_BUSY && txn_err && retry_q == 2'h0);
endmodule

/* File: desc_decode_map.svh */
// Bit positions, codes and timing constants of the interrupt transfer descriptor
`ifndef DESC_DECODE_MAP_SVH
`define DESC_DECODE_MAP_SVH
`define DESC_VALID_BIT     0
`define DESC_BYTES_LSB     3
`define DESC_BYTES_MSB     17
`define DESC_MAXLEN_LSB    18
`define DESC_MAXLEN_MSB    28
`define DESC_EP_LOW_BIT    31
`define DESC_EP_HIGH_LSB   32
`define DESC_EP_HIGH_MSB   34
`define DESC_ADDR_LSB      35
`define DESC_ADDR_MSB      41
`define DESC_TOKEN_LSB     42
`define DESC_TOKEN_MSB     43
`define DESC_KIND_LSB      44
`define DESC_KIND_MSB      45
`define DESC_SPLIT_BIT     46
`define DESC_SPEED_LSB     48
`define DESC_SPEED_MSB     49
`define TOKEN_CODE_OUT     2'h0
`define TOKEN_CODE_IN      2'h1
`define KIND_CODE_INTR     2'h3
`define SPEED_CODE_LOW     2'h2
`define SPEED_CODE_FULL    2'h0
`define RETRY_NONE         2'h0
`define FSLS_MAX_PKT       11'h040
`define XFER_MAX_BYTES     15'h1000
`define POLL_B_MIN         4'h4
`define UFRAME_NS          125000
`define CLK_PERIOD_NS      10
`define UFRAME_CYCLES      (`UFRAME_NS / `CLK_PERIOD_NS)
`endif

/* File: desc_decode_pkg.sv */
// Types shared by the descriptor decoder
package desc_decode_pkg;
   typedef enum logic [1:0] {TOKEN_OUT = 2'h0, TOKEN_IN = 2'h1, TOKEN_BAD = 2'h3} token_type;
   typedef enum logic [1:0] {SPEED_HIGH = 2'h0, SPEED_FULL = 2'h1, SPEED_LOW = 2'h2, SPEED_BAD = 2'h3} speed_type;
   typedef enum logic [3:0] {ST_IDLE = 4'h1, ST_WAIT = 4'h2, ST_ISSUE = 4'h4, ST_BUSY = 4'h8} state_type;
   typedef struct packed {
      logic        split;
      logic [1:0]  endpoint_kind;
      logic [1:0]  token_code;
      logic [1:0]  split_speed_code;
      logic [6:0]  function_addr;
      logic [3:0]  endpoint_number;
      logic [10:0] max_packet_len;
      logic [14:0] transfer_byte_count;
   } desc_fields_type;
endpackage

/* File: txn_partner.sv */
// Far-side transaction executor answering each scheduled transaction
module txn_partner
#(
   parameter int DLY_MAX = 3
)(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        txn_start_q,
   input  wire logic        fail_mode,
   input  wire logic [14:0] chunk,
   output logic             txn_done,
   output logic             txn_err,
   output logic [14:0]      done_bytes
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_q;
   int slow_q;
   always @(posedge sys_clk or negedge rst_n)
   begin
      txn_done <= 1'b0;
      txn_err <= 1'b0;
      // Byte count is only meaningful with a pulse, so it wanders in between
      done_bytes <= ~done_bytes;
      if (!rst_n)
      begin
         wait_q <= -1;
         slow_q <= 0;
         done_bytes <= 15'h0;
      end
      else if (txn_start_q)
      begin
         // Alternate prompt and slow answers
         wait_q <= slow_q;
         slow_q <= DLY_MAX - slow_q;
      end
      else if (wait_q > 0)
         wait_q <= wait_q - 1;
      else if (wait_q == 0)
      begin
         wait_q <= -1;
         txn_done <= !fail_mode;
         txn_err <= fail_mode;
         done_bytes <= chunk;
      end
   end
endmodule

/* File: interrupt_split_descriptor_decode_test.sv */
// Self-checking bench for the interrupt descriptor decoder
module interrupt_split_descriptor_decode_test
   import desc_decode_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int U = 4;
   logic sys_clk = 1'b0, rst_n = 1'b0, desc_load = 1'b0, active_in = 1'b0, fatal_err = 1'b0, fail_mode = 1'b0;
   logic [63:0] desc_word = 64'h0;
   logic [7:0]  uframe_code = 8'h0;
   logic [1:0]  cerr_in = 2'h0;
   logic [14:0] chunk = 15'h0;
   logic [14:0] done_bytes;
   logic        txn_done, txn_err, is_interrupt_q, param_fault_q, valid_q, active_q, txn_start_q, busy;
   logic [1:0]  retry_q;
   logic [14:0] bytes_left_q;
   desc_fields_type fields_q;
   token_type   token_q;
   speed_type   speed_q;
   int          error_cnt = 0, comparisons = 0, n, p, b, e, k;
   int          exp_q[$];
   logic [31:0] seed = 32'hA0B62CC6;
   logic [63:0] w;
   logic [4:0]  rc;

   interrupt_split_descriptor_decode #(.UFRAME_CYCLES(U)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
      .desc_load(desc_load), .desc_word(desc_word), .uframe_code(uframe_code), .active_in(active_in),
      .cerr_in(cerr_in), .txn_done(txn_done), .done_bytes(done_bytes), .txn_err(txn_err),
      .fatal_err(fatal_err), .fields_q(fields_q), .token_q(token_q), .speed_q(speed_q),
      .is_interrupt_q(is_interrupt_q), .param_fault_q(param_fault_q), .valid_q(valid_q),
      .active_q(active_q), .retry_q(retry_q), .bytes_left_q(bytes_left_q), .txn_start_q(txn_start_q), .busy(busy));
   txn_partner partner (.sys_clk(sys_clk), .rst_n(rst_n), .txn_start_q(txn_start_q), .fail_mode(fail_mode),
      .chunk(chunk), .txn_done(txn_done), .txn_err(txn_err), .done_bytes(done_bytes));

   always #5 sys_clk = ~sys_clk;

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task finish_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Active follows valid, as software must write them alike
   task load(input logic [63:0] d, input logic [7:0] uf, input logic [1:0] ce);
      @(posedge sys_clk);
      desc_load <= 1'b1;
      desc_word <= d;
      uframe_code <= uf;
      active_in <= d[0];
      cerr_in <= ce;
      @(posedge sys_clk);
      desc_load <= 1'b0;
      desc_word <= ~d;
      #1;
   endtask

   function logic [63:0] good(input logic [14:0] bytes);
      return {14'h0, 2'h2, 1'b0, 1'b1, 2'h3, 2'h1, 7'h55, 4'hA, 2'h0, 11'h040, bytes, 3'h1};
   endfunction

   task wait_start();
      n = 0;
      do
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      while (txn_start_q !== 1'b1 && n < 2000);
   endtask

   task txn();
      wait_start();
      k = 0;
      while (txn_done !== 1'b1 && txn_err !== 1'b1 && k < 10)
      begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      @(posedge sys_clk);
      #1;
   endtask

   task check_decode(input logic [63:0] d);
      desc_fields_type f;
      speed_type sp;
      f = {d[46], d[45:44], d[43:42], d[49:48], d[41:35], d[34:32], d[31], d[28:18], d[17:3]};
      sp = !d[46] ? SPEED_HIGH : d[49:48] == 2'h2 ? SPEED_LOW : d[49:48] == 2'h0 ? SPEED_FULL : SPEED_BAD;
      check(fields_q, f);
      check(token_q, d[43] ? TOKEN_BAD : d[42] ? TOKEN_IN : TOKEN_OUT);
      check(speed_q, sp);
      check(is_interrupt_q, d[45:44] == 2'h3);
      check(param_fault_q, (d[46] && d[28:18] > 11'h040) || d[17:3] > 15'h1000);
   endtask

   initial
   begin
      #200000;
      error_cnt++;
      finish_test();
   end

   initial
   begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      check(busy, 1'b0);
      check(valid_q, 1'b0);
      for (int i = 0; i < 40; i++)
      begin
         w = {rnd(), rnd()};
         w[0] = 1'b0;
         if (i % 2)
            w[28:18] = 11'h03C + 11'(rnd() % 8);
         if (i % 4 == 0)
            w[17:3] = 15'h0FFE + 15'(rnd() % 4);
         load(w, 8'(rnd()), 2'(rnd()));
         check_decode(w);
         check(busy, 1'b0);
      end
      $display("decode test done");
      chunk <= 15'h7FFF;
      for (b = 4; b <= 9; b++)
      begin
         rc = (b == 4) ? 5'h0 : 5'((1 << (b - 5)) | (rnd() & ((1 << (b - 5)) - 1)));
         p = 1 << (b - 1);
         load(good(15'h00A), {rc, 3'(rnd())}, 2'h3);
         check(active_q, 1'b1);
         txn();
         // First tick lands 1 to U edges after the load, start shows 1 edge after the last tick
         check(n >= p * U - 2 && n <= p * U + 1, 1'b1);
         check({valid_q, active_q, busy, bytes_left_q}, 18'h0);
      end
      $display("poll test done");
      chunk <= 15'h0028;
      e = 100;
      repeat (3)
      begin
         e = (e > 40) ? e - 40 : 0;
         exp_q.push_back(e);
      end
      load(good(15'h0064), 8'h0, 2'h3);
      repeat (3)
      begin
         txn();
         e = exp_q.pop_front();
         check(bytes_left_q, 15'(e));
         check({valid_q, active_q}, {2{e != 0}});
      end
      $display("byte count test done");
      fail_mode <= 1'b1;
      load(good(15'h0064), 8'h0, 2'h2);
      check(retry_q, 2'h2);
      for (int j = 0; j < 3; j++)
      begin
         txn();
         if (j < 2)
            check({valid_q, retry_q}, {1'b1, 2'(1 - j)});
         else
            check(valid_q, 1'b0);
      end
      $display("retry test done");
      fail_mode <= 1'b0;
      load(good(15'h0064), 8'h0, 2'h1);
      wait_start();
      // Fault lands while the transaction is in flight; its late answer must be ignored
      fatal_err <= 1'b1;
      @(posedge sys_clk);
      fatal_err <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
      check({valid_q, active_q, busy, bytes_left_q}, {3'h0, 15'h0064});
      $display("fatal test done");
      finish_test();
   end
endmodule
